// ==== pkg/timer_pkg.sv ====
// =========================================================
// Shared constants of the sixteen-bit timer
// =========================================================
package timer_pkg;

  // =========================================================
  // Register byte offsets (bus address width 12)
  // =========================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CONTROL = 12'h600; // Control word
  localparam logic [11:0] OFF_COUNT = 12'h610; // Running count
  localparam logic [11:0] OFF_PERIOD = 12'h620; // Wrap value
  localparam logic [11:0] OFF_STATUS = 12'h630; // Sticky events
  localparam logic [11:0] OFF_MASK = 12'h640; // Event mask

  // Alias operations in address bits 3:2
  localparam logic [1:0] OP_WRITE = 2'h0; // Plain store
  localparam logic [1:0] OP_CLEAR = 2'h1; // Base plus 0x4
  localparam logic [1:0] OP_SET = 2'h2; // Base plus 0x8
  localparam logic [1:0] OP_INVERT = 2'h3; // Base plus 0xC

  // =========================================================
  // Control field positions
  // =========================================================
  localparam int BIT_ENABLE = 15;
  localparam int BIT_STOP_IN_IDLE = 13;
  localparam int BIT_ASYNC_WRITE_DISABLE = 12;
  localparam int BIT_ASYNC_WRITE_IN_PROGRESS = 11;
  localparam int BIT_GATED_ACCUMULATION_ENABLE = 7;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_EXTERNAL_CLOCK_SYNCHRONISE = 2;
  localparam int BIT_CLOCK_SOURCE_SELECT = 1;

  // Writable control bits; all others read zero except bit 11, write in progress
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_B0B6;

  // Status and mask fields
  localparam int EVT_PERIOD_MATCH = 0; // Count wrapped at period
  localparam int EVT_GATE_CLOSE = 1; // Gate fell while gating
  localparam int EVT_W = 2;

  // =========================================================
  // Reset values
  // =========================================================
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;

  // =========================================================
  // Prescale ratios by select code
  // =========================================================
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] PS_LAST_DIV1 = 8'h00; // Ratio minus one
  localparam logic [7:0] PS_LAST_DIV8 = 8'h07;
  localparam logic [7:0] PS_LAST_DIV64 = 8'h3F;
  localparam logic [7:0] PS_LAST_DIV256 = 8'hFF;

endpackage : timer_pkg

// ==== logic/timer_prescaler.sv ====
`timescale 1ns/1ps
// =========================================================
// Input clock prescaler: passes one tick in 1, 8, 64 or 256
// =========================================================
module timer_prescaler
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_clear,
  input wire logic [1:0] i_sel,
  // Ticks
  input wire logic i_tick,
  output logic o_tick
);

  logic [7:0] cnt_ff; // Ticks seen since last output
  logic [7:0] last; // Terminal count for ratio

  // =========================================================
  // Ratio decode
  // =========================================================
  always_comb
  begin
    case (i_sel)
      timer_pkg::PS_DIV1: last = timer_pkg::PS_LAST_DIV1;
      timer_pkg::PS_DIV8: last = timer_pkg::PS_LAST_DIV8;
      timer_pkg::PS_DIV64: last = timer_pkg::PS_LAST_DIV64;
      default: last = timer_pkg::PS_LAST_DIV256;
    endcase
  end

  // Output pulse on the tick that reaches the terminal count
  assign o_tick = i_tick & (cnt_ff >= last);

  // =========================================================
  // Tick counter; >= guards a ratio lowered mid-count
  // =========================================================
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || i_clear)
    begin
      cnt_ff <= 8'h00;
    end
    else if (o_tick)
    begin
      cnt_ff <= 8'h00;
    end
    else if (i_tick)
    begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

endmodule : timer_prescaler

// ==== logic/type_a_timer.sv ====
`timescale 1ns/1ps
module type_a_timer
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Avalon-MM slave
  input wire logic [11:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Device pins and system state
  input wire logic i_ext_clk,
  input wire logic i_gate,
  input wire logic i_idle,
  // Interrupt
  output logic o_irq
);

  // =========================================================
  // Declarations
  logic [31:0] control_ff; // Stored control bits
  logic [15:0] count_ff; // Running count
  logic [15:0] period_ff; // Wrap value
  logic [timer_pkg::EVT_W-1:0] status_ff; // Sticky events
  logic [timer_pkg::EVT_W-1:0] mask_ff; // Event enables
  logic [15:0] pend_val_ff; // Async count write waiting
  logic pend_ff; // Async count write pending
  logic rd_done_ff; // Read answered this cycle
  logic [31:0] readdata_ff; // Registered read data
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff; // External clock sync
  logic gate_s1_ff, gate_s2_ff, gate_s3_ff; // Gate pin sync

  logic enable, stop_idle, wr_disable, gate_en, sync_sel, src_ext;
  logic [1:0] ps_sel;
  logic async_mode; // External source, unsynchronised
  logic ext_rise; // Synced external edge
  logic gate_fall; // Synced gate falling edge
  logic gating; // Gated accumulation active
  logic run; // Timer may advance this cycle
  logic src_tick; // Tick into the prescaler
  logic ps_tick; // Prescaled tick
  logic wrap; // Count matched period on a tick
  logic accept; // Bus write accepted this cycle
  logic [1:0] op; // Alias operation
  logic [11:0] base; // Address with alias bits removed
  logic [31:0] be_mask; // Byte lanes to bits
  logic wr_control, wr_count, wr_period, wr_status, wr_mask;
  logic count_wr_take; // Count write not dropped
  logic [31:0] nxt_control;
  logic [31:0] nxt_count;
  logic [31:0] nxt_period;
  logic [31:0] status_word;
  logic [timer_pkg::EVT_W-1:0] evt; // Events this cycle
  logic [31:0] rd_word;

  // =========================================================
  // Alias write helper: applies op to selected byte lanes
  function automatic logic [31:0] alias_apply
  (
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [1:0] o,
    input logic [31:0] m
  );
    logic [31:0] f;
    f = old;
    case (o)
      timer_pkg::OP_WRITE: f = wd;
      timer_pkg::OP_CLEAR: f = old & ~wd;
      timer_pkg::OP_SET: f = old | wd;
      default: f = old ^ wd;
    endcase
    return (old & ~m) | (f & m);
  endfunction : alias_apply

  // =========================================================
  // Control field decode
  assign enable = control_ff[timer_pkg::BIT_ENABLE];
  assign stop_idle = control_ff[timer_pkg::BIT_STOP_IN_IDLE];
  assign wr_disable = control_ff[timer_pkg::BIT_ASYNC_WRITE_DISABLE];
  assign gate_en = control_ff[timer_pkg::BIT_GATED_ACCUMULATION_ENABLE];
  assign ps_sel = control_ff[timer_pkg::BIT_PRESCALE_LO +: 2];
  assign sync_sel = control_ff[timer_pkg::BIT_EXTERNAL_CLOCK_SYNCHRONISE];
  assign src_ext = control_ff[timer_pkg::BIT_CLOCK_SOURCE_SELECT];
  assign async_mode = src_ext & ~sync_sel;

  // =========================================================
  // Pin synchronisers; edges compare the second and third stages
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      gate_s1_ff <= 1'b0;
      gate_s2_ff <= 1'b0;
      gate_s3_ff <= 1'b0;
    end
    else
    begin
      ext_s1_ff <= i_ext_clk;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      gate_s1_ff <= i_gate;
      gate_s2_ff <= gate_s1_ff;
      gate_s3_ff <= gate_s2_ff;
    end
  end

  assign ext_rise = ext_s2_ff & ~ext_s3_ff;
  assign gate_fall = ~gate_s2_ff & gate_s3_ff;

  // =========================================================
  // Tick source selection
  // Gate bit counts only with the internal source
  assign gating = ~src_ext & gate_en;
  // Idle stop only when stop-in-idle is set
  assign run = enable & ~(stop_idle & i_idle);
  // Off, pin edge, synced gate level, or bus clock every cycle
  assign src_tick = !run ? 1'b0 :
                    src_ext ? ext_rise :
                    gating ? gate_s2_ff :
                    1'b1;

  // Prescaler restarts whenever the enable bit is clear; an idle stop keeps its count
  timer_prescaler u_prescaler
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_clear(~enable),
    .i_sel(ps_sel),
    .i_tick(src_tick),
    .o_tick(ps_tick)
  );

  assign wrap = ps_tick & (count_ff == period_ff);

  // =========================================================
  // Bus decode; reads wait one cycle for registered data
  assign o_waitrequest = i_read & ~rd_done_ff;
  assign accept = i_write & ~i_read;
  assign op = i_address[3:2];
  assign base = {i_address[11:4], 4'h0};
  assign be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                    {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  assign wr_control = accept & (base == timer_pkg::OFF_CONTROL);
  assign wr_count = accept & (base == timer_pkg::OFF_COUNT);
  assign wr_period = accept & (base == timer_pkg::OFF_PERIOD);
  // Event registers have no aliases
  assign wr_status = accept & (i_address == timer_pkg::OFF_STATUS);
  assign wr_mask = accept & (i_address == timer_pkg::OFF_MASK);

  // Alias arithmetic on control, count and period
  assign nxt_control = alias_apply(control_ff, i_writedata, op,
                                   be_mask & timer_pkg::CONTROL_WMASK);
  assign nxt_count = alias_apply({16'h0000, count_ff}, i_writedata, op,
                                 be_mask & 32'h0000_FFFF);
  assign nxt_period = alias_apply({16'h0000, period_ff}, i_writedata, op,
                                  be_mask & 32'h0000_FFFF);

  // Async write dropped while one is already pending and write-disable is set
  assign count_wr_take = wr_count &
                         ~(async_mode & wr_disable & pend_ff);

  // =========================================================
  // Control register; unimplemented bits never store
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      control_ff <= timer_pkg::RST_CONTROL;
    end
    else if (wr_control)
    begin
      control_ff <= nxt_control;
    end
  end

  // =========================================================
  // Period register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      period_ff <= timer_pkg::RST_PERIOD;
    end
    else if (wr_period)
    begin
      period_ff <= nxt_period[15:0];
    end
  end

  // =========================================================
  // Pending async write; lands on the next external edge
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      pend_ff <= 1'b0;
      pend_val_ff <= timer_pkg::RST_COUNT;
    end
    else if (count_wr_take && async_mode)
    begin
      pend_ff <= 1'b1;
      pend_val_ff <= nxt_count[15:0]; // Newest write wins
    end
    else if (pend_ff && (ext_rise || !async_mode))
    begin
      pend_ff <= 1'b0;
    end
  end

  // =========================================================
  // Count register; a bus write beats a tick
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      count_ff <= timer_pkg::RST_COUNT;
    end
    else if (count_wr_take && !async_mode)
    begin
      count_ff <= nxt_count[15:0];
    end
    else if (pend_ff && (ext_rise || !async_mode))
    begin
      count_ff <= pend_val_ff; // Held write takes over the tick
    end
    else if (wrap)
    begin
      count_ff <= 16'h0000;
    end
    else if (ps_tick)
    begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // =========================================================
  // Events, sticky status, mask and interrupt
  assign evt[timer_pkg::EVT_PERIOD_MATCH] = wrap;
  assign evt[timer_pkg::EVT_GATE_CLOSE] = run & gating & gate_fall;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      status_ff <= '0;
    end
    else
    begin
      status_ff <= (status_ff & ~({timer_pkg::EVT_W{wr_status}} &
                    i_writedata[timer_pkg::EVT_W-1:0] &
                    be_mask[timer_pkg::EVT_W-1:0])) | evt;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      mask_ff <= '0;
    end
    else if (wr_mask && i_byteenable[0])
    begin
      mask_ff <= i_writedata[timer_pkg::EVT_W-1:0];
    end
  end

  assign o_irq = |(status_ff & mask_ff);

  // =========================================================
  // Read mux; unmapped addresses read zero
  assign status_word = {{(32-timer_pkg::EVT_W){1'b0}}, status_ff};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    // Control, count and period aliases read back the base register
    case (base)
      timer_pkg::OFF_CONTROL:
      begin
        rd_word = control_ff & timer_pkg::CONTROL_WMASK;
        rd_word[timer_pkg::BIT_ASYNC_WRITE_IN_PROGRESS] =
          pend_ff & async_mode;
      end
      timer_pkg::OFF_COUNT: rd_word = {16'h0000, count_ff};
      timer_pkg::OFF_PERIOD: rd_word = {16'h0000, period_ff};
      // Event registers answer only at their exact address
      timer_pkg::OFF_STATUS:
        rd_word = (i_address[3:0] == 4'h0) ? status_word : 32'h0;
      timer_pkg::OFF_MASK:
        rd_word = (i_address[3:0] == 4'h0) ?
          {{(32-timer_pkg::EVT_W){1'b0}}, mask_ff} : 32'h0;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // =========================================================
  // Read answer register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      rd_done_ff <= 1'b0;
      readdata_ff <= 32'h0000_0000;
    end
    else
    begin
      // Answer in the cycle after the read is seen
      rd_done_ff <= i_read & ~rd_done_ff;
      readdata_ff <= (i_read && !rd_done_ff) ? rd_word : readdata_ff;
    end
  end

  assign o_readdata = readdata_ff;
endmodule : type_a_timer

// ==== bench/type_a_timer_asserts.sv ====
`timescale 1ns/1ps
// =========================================================
// Port-level checks of the sixteen-bit timer
// =========================================================
module type_a_timer_asserts
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register bus
  input wire logic [11:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // Interrupt
  input wire logic o_irq
);
  // Read answered in this cycle
  logic rd_done;
  assign rd_done = i_read & ~o_waitrequest;

  // One clock domain, reset disables every check
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // =========================================================
  // Bus handshake
  // =========================================================
  a_read_one_wait:
    assert property ($rose(i_read) |-> o_waitrequest ##1 !o_waitrequest)
      else $error("read did not answer after one wait state");
  a_write_no_wait:
    assert property (i_write && !i_read |-> !o_waitrequest)
      else $error("write was held off");
  // Data only moves when a read is being answered
  a_readdata_holds:
    assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
      else $error("read data changed without a read");

  // =========================================================
  // Read-back contents
  // =========================================================
  a_ctrl_zero_bits:
    assert property (rd_done && i_address == timer_pkg::OFF_CONTROL |->
      (o_readdata & ~(timer_pkg::CONTROL_WMASK | 32'h0000_0800)) == 32'h0)
      else $error("unimplemented control bit read as one");
  a_wip_sync_zero:
    assert property (rd_done && i_address == timer_pkg::OFF_CONTROL &&
      !(o_readdata[1] && !o_readdata[2]) |-> !o_readdata[11])
      else $error("write-in-progress set in synchronous mode");
  a_count_upper_zero:
    assert property (rd_done && i_address[11:4] inside {8'h61, 8'h62} |->
      o_readdata[31:16] == 16'h0)
      else $error("count or period upper half not zero");
  a_event_upper_zero:
    assert property (rd_done && i_address[11:4] inside {8'h63, 8'h64} |->
      o_readdata[31:2] == 30'h0)
      else $error("status or mask unused bits not zero");
  a_unmapped_zero:
    assert property (rd_done && i_address[11:8] != 4'h6 |->
      o_readdata == 32'h0)
      else $error("unmapped read returned data");

  // =========================================================
  // Interrupt
  // =========================================================
  a_mask_quiets_irq:
    assert property (i_write && i_address == timer_pkg::OFF_MASK &&
      i_byteenable[0] && i_writedata[1:0] == 2'h0 |=> !o_irq)
      else $error("interrupt stayed high with all events masked");

  // Main scenarios reached
  c_count_read: cover property (rd_done && i_address == timer_pkg::OFF_COUNT);
  c_irq_rise: cover property ($rose(o_irq));
  c_invert_alias: cover property (i_write && i_address[3:2] == 2'h3);
endmodule : type_a_timer_asserts

// ==== bench/type_a_timer_tb_top.sv ====
`timescale 1ns/1ps
// =========================================================
// Self-checking bench of the sixteen-bit timer
// =========================================================
module type_a_timer_tb_top;
  // Design inputs
  logic i_clk;
  logic i_rst_b;
  logic [11:0] i_address;
  logic i_read;
  logic i_write;
  logic [3:0] i_byteenable;
  logic [31:0] i_writedata;
  logic i_ext_clk;
  logic i_gate;
  logic i_idle;
  // Design outputs
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_irq;
  // Bookkeeping
  int errors;
  int samples_checked;
  int cyc; // Free-running cycle stamp
  int t1;
  int seed;
  logic [31:0] rd; // Last read data
  logic [31:0] v; // Expected register copy
  logic [31:0] d;

  type_a_timer u_type_a_timer
  (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
    .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_ext_clk(i_ext_clk),
    .i_gate(i_gate), .i_idle(i_idle), .o_irq(o_irq)
  );

  // Clock, 100 ns period
  always #50 i_clk = ~i_clk;
  // Stamp used for interval checks
  always @(posedge i_clk) cyc <= cyc + 1;

  // =========================================================
  // Expectation helpers
  // =========================================================
  function automatic logic [31:0] alias_apply(input logic [31:0] o,
    input logic [31:0] w, input logic [1:0] op);
    case (op)
      2'h1: return o & ~w; // Clear alias
      2'h2: return o | w; // Set alias
      2'h3: return o ^ w; // Invert alias
      default: return w; // Plain store
    endcase
  endfunction : alias_apply

  function automatic int ratio(input int code);
    return (code == 0) ? 1 : (code == 1) ? 8 : (code == 2) ? 64 : 256;
  endfunction : ratio

  // =========================================================
  // Compare and bus tasks
  // =========================================================
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // Hold the request until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    int n;
    n = 0;
    i_address <= a;
    i_writedata <= wd;
    i_write <= wr;
    i_read <= !wr;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_waitrequest !== 1'b0 && n < 64);
    if (n >= 64)
      errors++;
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk); // Idle cycle after every access
  endtask : bus_xfer

  // Interrupt level, looked at mid-cycle where it has settled
  task automatic check_irq(input logic e);
    @(negedge i_clk);
    check_bit(o_irq, e);
    @(posedge i_clk);
  endtask : check_irq

  // Slow external clock pulses, longer than the synchroniser delay
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      i_ext_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_ext_clk <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask : ext_pulses

  // Bounded wait for the interrupt level
  task automatic wait_irq();
    int n;
    n = 0;
    while (o_irq !== 1'b1 && n < 6000)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 6000)
      errors++;
  endtask : wait_irq

  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // =========================================================
  // Main sequence
  // =========================================================
  initial
  begin
    seed = 32'hdd1fd51c;
    {i_clk, i_rst_b, i_read, i_write, i_ext_clk, i_gate, i_idle} = 7'h0;
    {i_address, i_writedata, errors, samples_checked, cyc} = '0;
    i_byteenable = 4'hF;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    // Reset values, then an unmapped place
    bus_xfer(0, timer_pkg::OFF_CONTROL, 0);
    check_val(rd, 32'h0000_0000);
    bus_xfer(0, timer_pkg::OFF_PERIOD, 0);
    check_val(rd, 32'h0000_FFFF);
    bus_xfer(1, 12'h700, 32'hFFFF_FFFF);
    bus_xfer(0, 12'h700, 0);
    check_val(rd, 32'h0000_0000);
    // All ones into control: only writable bits stay
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'hFFFF_FFFF);
    bus_xfer(0, timer_pkg::OFF_CONTROL, 0);
    check_val(rd, timer_pkg::CONTROL_WMASK);
    bus_xfer(1, timer_pkg::OFF_CONTROL, 0);
    // Random values through every alias of the period
    v = 32'h0000_FFFF;
    for (int k = 0; k < 8; k++)
    begin
      d = $random(seed) & 32'h0000_FFFF;
      bus_xfer(1, timer_pkg::OFF_PERIOD | {8'h00, k[1:0], 2'h0}, d);
      v = alias_apply(v, d, k[1:0]) & 32'h0000_FFFF;
      bus_xfer(0, timer_pkg::OFF_PERIOD, 0);
      check_val(rd, v);
    end
    // Low byte lane only: the upper period byte must stay
    i_byteenable <= 4'h1;
    bus_xfer(1, timer_pkg::OFF_PERIOD, 32'h0000_A5A5);
    i_byteenable <= 4'hF;
    bus_xfer(0, timer_pkg::OFF_PERIOD, 0);
    check_val(rd, (v & 32'h0000_FF00) | 32'h0000_00A5);
    // Wrap interval for each prescale code, seen on the interrupt
    bus_xfer(1, timer_pkg::OFF_PERIOD, 32'd9);
    bus_xfer(1, timer_pkg::OFF_MASK, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      bus_xfer(1, timer_pkg::OFF_COUNT, 0);
      bus_xfer(1, timer_pkg::OFF_CONTROL,
               32'h0000_8000 | {26'h0, k[1:0], 4'h0});
      wait_irq();
      t1 = cyc;
      bus_xfer(1, timer_pkg::OFF_STATUS, 32'h1);
      wait_irq();
      check_val(32'(cyc - t1), 32'(10 * ratio(k)));
      bus_xfer(1, timer_pkg::OFF_CONTROL, 0);
      if (k < 3)
        bus_xfer(1, timer_pkg::OFF_STATUS, 32'h1);
    end
    // Disabled count stands; mask and clear the pending event
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    v = rd;
    repeat (20) @(posedge i_clk);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_val(rd, v);
    check_bit(v <= 32'd9, 1'b1);
    bus_xfer(1, timer_pkg::OFF_MASK, 0);
    check_irq(1'b0);
    bus_xfer(1, timer_pkg::OFF_MASK, 32'h1);
    check_irq(1'b1);
    bus_xfer(1, timer_pkg::OFF_STATUS, 32'h1);
    check_irq(1'b0);
    // Idle with and without stop-in-idle
    bus_xfer(1, timer_pkg::OFF_PERIOD, 32'h0000_FFFF);
    bus_xfer(1, timer_pkg::OFF_COUNT, 0);
    i_idle <= 1'b1;
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'h0000_A000);
    repeat (20) @(posedge i_clk);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_val(rd, 32'h0);
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'h0000_8000);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_bit(rd != 32'h0, 1'b1);
    i_idle <= 1'b0;
    // Gated accumulation on the internal clock
    bus_xfer(1, timer_pkg::OFF_CONTROL, 0);
    bus_xfer(1, timer_pkg::OFF_COUNT, 0);
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'h0000_8080);
    repeat (20) @(posedge i_clk);
    i_gate <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_gate <= 1'b0;
    repeat (10) @(posedge i_clk);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_val(rd, 32'd10);
    bus_xfer(0, timer_pkg::OFF_STATUS, 0);
    check_val(rd, 32'h2);
    bus_xfer(1, timer_pkg::OFF_STATUS, 32'h3);
    // External source, gate ignored although the gate is low
    bus_xfer(1, timer_pkg::OFF_CONTROL, 0);
    bus_xfer(1, timer_pkg::OFF_COUNT, 0);
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'h0000_8086);
    ext_pulses(5);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_val(rd, 32'd5);
    // Asynchronous mode with write-disable: second write dropped
    bus_xfer(1, timer_pkg::OFF_CONTROL, 0);
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'h0000_9002);
    v = $random(seed) & 32'h0000_FFFF;
    bus_xfer(1, timer_pkg::OFF_COUNT, v);
    bus_xfer(0, timer_pkg::OFF_CONTROL, 0);
    check_val(rd & 32'h0000_0800, 32'h0000_0800);
    bus_xfer(1, timer_pkg::OFF_COUNT, ~v & 32'h0000_FFFF);
    ext_pulses(1);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_val(rd, v);
    bus_xfer(0, timer_pkg::OFF_CONTROL, 0);
    check_val(rd & 32'h0000_0800, 32'h0);
    // Without write-disable the later write wins
    bus_xfer(1, timer_pkg::OFF_CONTROL, 32'h0000_8002);
    bus_xfer(1, timer_pkg::OFF_COUNT, v ^ 32'h0000_00FF);
    v = $random(seed) & 32'h0000_FFFF;
    bus_xfer(1, timer_pkg::OFF_COUNT, v);
    ext_pulses(1);
    bus_xfer(0, timer_pkg::OFF_COUNT, 0);
    check_val(rd, v);
    complete_run();
  end

  // Watchdog well beyond the longest expected run
  initial
  begin
    repeat (40000) @(posedge i_clk);
    errors++;
    complete_run();
  end
endmodule : type_a_timer_tb_top

bind type_a_timer type_a_timer_asserts u_type_a_timer_asserts
(
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
  .i_writedata(i_writedata), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_irq(o_irq)
);
